// >>> design/clock_divider.sv
// 50% duty divider counting enable ticks
// assumes tick and ratio come from core clock logic
`timescale 1ns/1ps
module clock_divider #(
  parameter int W = 24
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         srst,
  // control
  input  wire logic         tick,
  input  wire logic [W-1:0] ratio,
  input  wire logic         restart,
  // output
  output logic              div_clk
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         clk_next;

  // ----------------------------------------------------------------
  // counter and half-period compare
  // ----------------------------------------------------------------
  wire [W-1:0] ratio_m1 = ratio - {{(W-1){1'b0}}, 1'b1};
  wire [W-1:0] half     = W'(({1'b0, ratio} + {{W{1'b0}}, 1'b1}) >> 1);
  wire         usable   = ratio > {{(W-2){1'b0}}, 2'b01};

  assign cnt_next = (cnt_reg >= ratio_m1) ? '0 : cnt_reg + {{(W-1){1'b0}}, 1'b1};
  assign clk_next = usable & (cnt_next < half);

  always_ff @(posedge core_clk) begin
    if (srst || restart || !usable) begin
      cnt_reg <= '0;
      div_clk <= 1'b0;
    end else if (tick) begin
      cnt_reg <= cnt_next;
      div_clk <= clk_next;
    end
  end

  cnt_bound_a: assert property (@(posedge core_clk) disable iff (srst)
    usable |-> cnt_reg <= ratio_m1)
    else $error("divider count past ratio");

endmodule

// >>> design/frame_pulse_gen.sv
// frame pulse timed from a sibling clock level
// assumes the sibling level is produced on the core clock
`timescale 1ns/1ps
module frame_pulse_gen (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // controls and pulse
  frame_ctrl_if.gen fc
);

  logic        prev_reg;
  logic [15:0] cnt_reg;
  logic        pulse_reg;

  // ----------------------------------------------------------------
  // sibling edges and frame position
  // ----------------------------------------------------------------
  wire        rise     = fc.src_level & ~prev_reg;
  wire        fall     = ~fc.src_level & prev_reg;
  wire [15:0] rate_m1  = fc.rate - 16'h0001;
  wire        at_last  = cnt_reg >= rate_m1;
  wire        at_first = cnt_reg == 16'h0000;
  wire        run      = fc.enable & (fc.rate != 16'h0000);
  // boundary at leading edge or centre
  wire        set_p    = fc.leading ? (rise & at_last) : (fall & at_last);
  wire        clr_p    = fc.leading ? rise : (fall & at_first);
  wire [15:0] cnt_next = at_last ? 16'h0000 : cnt_reg + 16'h0001;

  always_ff @(posedge core_clk) begin
    if (srst || !run) begin
      prev_reg  <= 1'b0;
      cnt_reg   <= 16'h0000;
      pulse_reg <= 1'b0;
    end else begin
      prev_reg  <= fc.src_level;
      cnt_reg   <= rise ? cnt_next : cnt_reg;
      pulse_reg <= set_p | (pulse_reg & ~clr_p);
    end
  end

  assign fc.active = pulse_reg;

  // pulse starts only at the frame boundary
  pulse_start_a: assert property (@(posedge core_clk) disable iff (srst)
    (run && $past(run) && $rose(pulse_reg)) |-> $past(at_last))
    else $error("frame pulse started off boundary");

endmodule

// >>> design/synth_post_divider_frame_gen.sv
// output dividers A and B of the second synthesizer with AXI4-Lite registers
// assumes core_clk is the synthesizer output clock; tick and sibling
// levels are produced by logic on that same clock
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps

// Behaviour
// - four mode bits choose frame pulse, low-frequency clock or regular clock
// - regular mode gives 50% clock at input divided by 24-bit value
// - outside special mode polarity and format bits are ratio bits
// - A special with selector 00 gives low clock, twice base over low bits
// - A special with other selector gives pulse one sibling period wide
// - B special, selector not 01: low bits count periods between pulses
// - B special, selector 01: low bits divide twice base into low clock
// - B selector: 00 A, 01 low clock, 10 C, 11 D
// - frame source is a sibling clock; pulse width one of its periods
// - bit 18 clear gives active-high pulse, set gives active-low
// - bit 19 clear puts boundary mid-pulse, set at first edge
// - A selector: 00 low clock, 01 B, 10 C, 11 D
module synth_post_divider_frame_gen (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // axi4-lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // synthesizer side
  input  wire logic        base2x_tick,
  input  wire logic        clk_c_level,
  input  wire logic        clk_d_level,
  // divider outputs
  output logic             out_a,
  output logic             out_b
);

  logic [23:0]                cfg_a_reg;
  logic [23:0]                cfg_b_reg;
  logic [11:0]                awaddr_reg;
  logic [31:0]                wdata_reg;
  logic [3:0]                 wstrb_reg;
  logic                       out_a_next;
  logic                       out_b_next;
  logic                       div_a_clk;
  logic                       div_b_clk;
  synth_pkg::out_mode_type    mode_a;
  synth_pkg::out_mode_type    mode_b;

  frame_ctrl_if fa ();
  frame_ctrl_if fb ();

  // ----------------------------------------------------------------
  // write channel handshakes
  // ----------------------------------------------------------------
  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire b_done   = s_axi_bvalid & s_axi_bready;
  wire hit_a_w  = awaddr_reg == synth_pkg::ADDR_CFG_A;
  wire hit_b_w  = awaddr_reg == synth_pkg::ADDR_CFG_B;
  wire hit_s_w  = awaddr_reg == synth_pkg::ADDR_STATUS;
  wire wr_cfg_a = do_write & hit_a_w;
  wire wr_cfg_b = do_write & hit_b_w;
  wire wr_ok    = hit_a_w | hit_b_w | hit_s_w;

  // byte-lane merge of a 24-bit configuration word
  function automatic logic [23:0] merge24(input logic [23:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    logic [23:0] res;
    res = old;
    for (int i = 0; i < 3; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_awready <= 1'b1;
      awaddr_reg    <= 12'h000;
    end else if (aw_take) begin
      s_axi_awready <= 1'b0;
      awaddr_reg    <= s_axi_awaddr;
    end else if (b_done) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_wready <= 1'b1;
      wdata_reg    <= 32'h00000000;
      wstrb_reg    <= 4'h0;
    end else if (w_take) begin
      s_axi_wready <= 1'b0;
      wdata_reg    <= s_axi_wdata;
      wstrb_reg    <= s_axi_wstrb;
    end else if (b_done) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= synth_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? synth_pkg::RESP_OKAY : synth_pkg::RESP_SLVERR;
    end else if (b_done) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_a_reg <= synth_pkg::CFG_RESET;
      cfg_b_reg <= synth_pkg::CFG_RESET;
    end else begin
      if (wr_cfg_a) begin
        cfg_a_reg <= merge24(cfg_a_reg, wdata_reg, wstrb_reg);
      end
      if (wr_cfg_b) begin
        cfg_b_reg <= merge24(cfg_b_reg, wdata_reg, wstrb_reg);
      end
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  wire        ar_take  = s_axi_arvalid & s_axi_arready;
  wire        r_done   = s_axi_rvalid & s_axi_rready;
  wire        hit_a_r  = s_axi_araddr == synth_pkg::ADDR_CFG_A;
  wire        hit_b_r  = s_axi_araddr == synth_pkg::ADDR_CFG_B;
  wire        hit_s_r  = s_axi_araddr == synth_pkg::ADDR_STATUS;
  wire [31:0] status_w = {26'h0, mode_b, mode_a, out_b, out_a};
  wire [31:0] rd_mux   = hit_a_r ? {8'h00, cfg_a_reg} :
                         hit_b_r ? {8'h00, cfg_b_reg} :
                         hit_s_r ? status_w : 32'h00000000;
  wire        rd_ok    = hit_a_r | hit_b_r | hit_s_r;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= synth_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_ok ? synth_pkg::RESP_OKAY : synth_pkg::RESP_SLVERR;
    end else if (r_done) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  wire [1:0] sel_a     = cfg_a_reg[synth_pkg::SRC_HI:synth_pkg::SRC_LO];
  wire [1:0] sel_b     = cfg_b_reg[synth_pkg::SRC_HI:synth_pkg::SRC_LO];
  wire       special_a = cfg_a_reg[synth_pkg::MODE_HI:synth_pkg::MODE_LO]
                         == synth_pkg::MODE_SPECIAL;
  wire       special_b = cfg_b_reg[synth_pkg::MODE_HI:synth_pkg::MODE_LO]
                         == synth_pkg::MODE_SPECIAL;
  assign mode_a = !special_a ? synth_pkg::MODE_REGULAR :
                  (sel_a == synth_pkg::SEL_A_LOW) ? synth_pkg::MODE_LOW :
                  synth_pkg::MODE_FRAME;
  assign mode_b = !special_b ? synth_pkg::MODE_REGULAR :
                  (sel_b == synth_pkg::SEL_B_LOW) ? synth_pkg::MODE_LOW :
                  synth_pkg::MODE_FRAME;

  // ----------------------------------------------------------------
  // clock dividers: full ratio or low bits on base ticks
  // ----------------------------------------------------------------
  wire        low_a   = mode_a == synth_pkg::MODE_LOW;
  wire        low_b   = mode_b == synth_pkg::MODE_LOW;
  // low clock steps on base ticks
  wire        tick_a  = low_a ? base2x_tick : 1'b1;
  wire        tick_b  = low_b ? base2x_tick : 1'b1;
  wire [23:0] ratio_a = low_a ? {8'h00, cfg_a_reg[synth_pkg::RATE_HI:0]} : cfg_a_reg;
  wire [23:0] ratio_b = low_b ? {8'h00, cfg_b_reg[synth_pkg::RATE_HI:0]} : cfg_b_reg;

  clock_divider #(.W(synth_pkg::CFG_W)) div_a (
    .core_clk (core_clk),
    .srst     (srst),
    .tick     (tick_a),
    .ratio    (ratio_a),
    .restart  (wr_cfg_a),
    .div_clk  (div_a_clk)
  );

  clock_divider #(.W(synth_pkg::CFG_W)) div_b (
    .core_clk (core_clk),
    .srst     (srst),
    .tick     (tick_b),
    .ratio    (ratio_b),
    .restart  (wr_cfg_b),
    .div_clk  (div_b_clk)
  );

  // ----------------------------------------------------------------
  // frame pulse sources and controls
  // ----------------------------------------------------------------
  // divider A and B source select
  wire src_a = (sel_a == synth_pkg::SEL_A_FROM_B) ? out_b :
               (sel_a == synth_pkg::SEL_FROM_C)   ? clk_c_level :
               (sel_a == synth_pkg::SEL_FROM_D)   ? clk_d_level : 1'b0;
  wire src_b = (sel_b == synth_pkg::SEL_B_FROM_A) ? out_a :
               (sel_b == synth_pkg::SEL_FROM_C)   ? clk_c_level :
               (sel_b == synth_pkg::SEL_FROM_D)   ? clk_d_level : 1'b0;

  assign fa.enable    = (mode_a == synth_pkg::MODE_FRAME) & ~wr_cfg_a;
  assign fa.src_level = src_a;
  assign fa.leading   = cfg_a_reg[synth_pkg::TYPE_BIT];
  assign fa.rate      = cfg_a_reg[synth_pkg::RATE_HI:0];
  assign fb.enable    = (mode_b == synth_pkg::MODE_FRAME) & ~wr_cfg_b;
  assign fb.src_level = src_b;
  assign fb.leading   = cfg_b_reg[synth_pkg::TYPE_BIT];
  assign fb.rate      = cfg_b_reg[synth_pkg::RATE_HI:0];

  frame_pulse_gen gen_a (
    .core_clk (core_clk),
    .srst     (srst),
    .fc       (fa.gen)
  );

  frame_pulse_gen gen_b (
    .core_clk (core_clk),
    .srst     (srst),
    .fc       (fb.gen)
  );

  // ----------------------------------------------------------------
  // output selection and registers
  // ----------------------------------------------------------------
  // polarity applied to frame pulse
  always_comb begin
    case (mode_a)
      synth_pkg::MODE_FRAME: out_a_next = fa.active ^ cfg_a_reg[synth_pkg::POL_BIT];
      synth_pkg::MODE_LOW:   out_a_next = div_a_clk;
      default:               out_a_next = div_a_clk;
    endcase
  end

  always_comb begin
    case (mode_b)
      synth_pkg::MODE_FRAME: out_b_next = fb.active ^ cfg_b_reg[synth_pkg::POL_BIT];
      synth_pkg::MODE_LOW:   out_b_next = div_b_clk;
      default:               out_b_next = div_b_clk;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      out_a <= 1'b0;
      out_b <= 1'b0;
    end else begin
      out_a <= out_a_next;
      out_b <= out_b_next;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  mode_decode_a: assert property (@(posedge core_clk) disable iff (srst)
    (mode_a == synth_pkg::MODE_REGULAR) == !special_a)
    else $error("mode A decode wrong");

  regular_ratio_a: assert property (@(posedge core_clk) disable iff (srst)
    (mode_b == synth_pkg::MODE_REGULAR) |-> (ratio_b == cfg_b_reg && tick_b))
    else $error("regular B ratio not full word");

  pol_ignored_a: assert property (@(posedge core_clk) disable iff (srst)
    (mode_a != synth_pkg::MODE_FRAME) |=> out_a == $past(div_a_clk))
    else $error("A output not the divider clock");

  low_a_tick_a: assert property (@(posedge core_clk) disable iff (srst)
    (special_a && sel_a == 2'h0) |-> (tick_a == base2x_tick && ratio_a[23:16] == 8'h00))
    else $error("A low clock not on base ticks");

  frame_a_sel_a: assert property (@(posedge core_clk) disable iff (srst)
    (special_a && sel_a != 2'h0) |-> fa.enable || wr_cfg_a)
    else $error("A frame mode not enabled");

  low_b_tick_a: assert property (@(posedge core_clk) disable iff (srst)
    (special_b && sel_b == 2'h1) |-> (low_b && tick_b == base2x_tick))
    else $error("B low clock not on base ticks");

  src_b_pick_a: assert property (@(posedge core_clk) disable iff (srst)
    (sel_b == 2'h0 |-> src_b == out_a) and (sel_b == 2'h2 |-> src_b == clk_c_level))
    else $error("B source select wrong");

  src_a_pick_a: assert property (@(posedge core_clk) disable iff (srst)
    (sel_a == 2'h1 |-> src_a == out_b) and (sel_a == 2'h3 |-> src_a == clk_d_level))
    else $error("A source select wrong");

  frame_pol_a: assert property (@(posedge core_clk) disable iff (srst)
    (mode_b == synth_pkg::MODE_FRAME) |=> out_b == ($past(fb.active) ^ $past(cfg_b_reg[18])))
    else $error("B frame polarity wrong");

  pulse_width_a: assert property (@(posedge core_clk) disable iff (srst)
    ($past(fa.enable) && fa.enable && $changed(fa.active) && !(fa.rate == 16'h0001))
      |-> $past(fa.src_level) != $past(fa.src_level, 2))
    else $error("A pulse edge not at a sibling edge");

  lead_edge_a: assert property (@(posedge core_clk) disable iff (srst)
    ($past(fb.enable) && fb.enable && fb.leading && $rose(fb.active))
      |-> ($past(fb.src_level) && !$past(fb.src_level, 2)))
    else $error("B leading pulse not at rising edge");

  sync_src_a: assert property (@(posedge core_clk) disable iff (srst)
    (mode_a == synth_pkg::MODE_LOW && !tick_a && !wr_cfg_a) |=> $stable(div_a_clk))
    else $error("A low clock moved without a tick");

endmodule

// >>> pkg/frame_ctrl_if.sv
// controls and result of one frame pulse generator
// assumes both ends run on the core clock
`timescale 1ns/1ps
interface frame_ctrl_if;
  logic        enable;
  logic        src_level;
  logic        leading;
  logic [15:0] rate;
  logic        active;

  modport ctl (output enable, output src_level, output leading, output rate, input active);
  modport gen (input enable, input src_level, input leading, input rate, output active);
endinterface

// >>> pkg/synth_pkg.sv
// constants for the second synthesizer output divider stage
// assumes one core clock and an AXI4-Lite register master
package synth_pkg;

  // ----------------------------------------------------------------
  // register map: printed indices, byte address is four times each
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 12;
  localparam logic [11:0] IDX_CFG_A   = 12'h08C;
  localparam logic [11:0] IDX_CFG_B   = 12'h08F;
  localparam logic [11:0] IDX_STATUS  = 12'h098;
  localparam logic [11:0] ADDR_CFG_A  = {IDX_CFG_A[9:0], 2'b00};
  localparam logic [11:0] ADDR_CFG_B  = {IDX_CFG_B[9:0], 2'b00};
  localparam logic [11:0] ADDR_STATUS = {IDX_STATUS[9:0], 2'b00};

  // ----------------------------------------------------------------
  // configuration fields and reset value
  // ----------------------------------------------------------------
  localparam int          CFG_W       = 24;
  localparam int          RATE_W      = 16;
  localparam logic [23:0] CFG_RESET   = 24'h000002;
  localparam int          MODE_HI     = 23;
  localparam int          MODE_LO     = 20;
  localparam int          TYPE_BIT    = 19;
  localparam int          POL_BIT     = 18;
  localparam int          SRC_HI      = 17;
  localparam int          SRC_LO      = 16;
  localparam int          RATE_HI     = 15;
  localparam logic [3:0]  MODE_SPECIAL = 4'hF;

  // source selector codes
  localparam logic [1:0]  SEL_A_LOW   = 2'h0;
  localparam logic [1:0]  SEL_A_FROM_B = 2'h1;
  localparam logic [1:0]  SEL_B_FROM_A = 2'h0;
  localparam logic [1:0]  SEL_B_LOW   = 2'h1;
  localparam logic [1:0]  SEL_FROM_C  = 2'h2;
  localparam logic [1:0]  SEL_FROM_D  = 2'h3;

  // ----------------------------------------------------------------
  // status fields and bus responses
  // ----------------------------------------------------------------
  localparam int          ST_OUT_A    = 0;
  localparam int          ST_OUT_B    = 1;
  localparam int          ST_MODE_A   = 2;
  localparam int          ST_MODE_B   = 4;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_REGULAR = 2'b00,
    MODE_LOW     = 2'b01,
    MODE_FRAME   = 2'b10
  } out_mode_type;

endpackage

// >>> tb/synth_partner.sv
// sibling clock levels and base tick for the output dividers
// assumes one core clock; levels change just after its rising edge
`timescale 1ns/1ps
module synth_partner #(
  parameter int TICK_P = 5,
  parameter int C_P    = 8,
  parameter int D_P    = 6
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // synthesizer side
  output logic      base2x_tick,
  output logic      clk_c_level,
  output logic      clk_d_level
);
  int t_cnt;
  int c_cnt;
  int d_cnt;

  always @(posedge core_clk) begin
    t_cnt <= (srst || t_cnt == TICK_P - 1) ? 0 : t_cnt + 1;
    c_cnt <= (srst || c_cnt == C_P - 1) ? 0 : c_cnt + 1;
    d_cnt <= (srst || d_cnt == D_P - 1) ? 0 : d_cnt + 1;
  end

  assign base2x_tick = (t_cnt == TICK_P - 1);
  assign clk_c_level = (c_cnt < C_P / 2);
  assign clk_d_level = (d_cnt < D_P / 2);
endmodule

// >>> tb/synth_post_divider_frame_gen_tb_top.sv
// self-checking bench for output dividers A and B
// assumes synth_partner supplies tick and sibling levels
`timescale 1ns/1ps
module synth_post_divider_frame_gen_tb_top;
  localparam int TP = 5;
  localparam logic [31:0] SIB [6] = '{32'h6, 32'h2, 32'h2, 32'hA, 32'h2, 32'h2};
  localparam logic [31:0] TGT [6] = '{32'hF80004, 32'hF60003, 32'hF30002,
                                      32'hF90002, 32'hFE0003, 32'hF30004};
  localparam int PER [6] = '{24, 24, 12, 20, 24, 24};
  localparam int HI [6]  = '{6, 16, 6, 10, 16, 6};
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        base2x_tick, clk_c_level, clk_d_level, out_a, out_b;
  int          bad_count = 0;
  int          checks = 0;
  int          cycles = 0;
  int          seed = 8184;

  always #50 core_clk = ~core_clk;

  synth_post_divider_frame_gen uut (
    .core_clk, .srst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .base2x_tick, .clk_c_level,
    .clk_d_level, .out_a, .out_b
  );
  synth_partner #(.TICK_P(TP), .C_P(8), .D_P(6)) far_side (
    .core_clk, .srst, .base2x_tick, .clk_c_level, .clk_d_level
  );

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish;
    end
  end

  // ----------------------------------------------------------------
  // bus cycles and output timing
  // ----------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge core_clk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge core_clk); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  function automatic logic pick(input bit w);
    return w ? out_b : out_a;
  endfunction

  // skips two edge pairs after a restart, then times one full period
  task automatic meas(input bit w, input int per_x, input int hi_x);
    int per;
    int hi;
    hi = 0;
    repeat (2) begin
      do @(posedge core_clk); while (pick(w) !== 1'b0);
      do @(posedge core_clk); while (pick(w) !== 1'b1);
    end
    while (pick(w) === 1'b1) begin
      hi++;
      @(posedge core_clk);
    end
    per = hi;
    while (pick(w) === 1'b0) begin
      per++;
      @(posedge core_clk);
    end
    chk(32'(per), 32'(per_x));
    chk(32'(hi), 32'(hi_x));
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    rd(synth_pkg::ADDR_CFG_A, d, r);
    chk(d, {8'h00, synth_pkg::CFG_RESET});
    rd(synth_pkg::ADDR_CFG_B, d, r);
    chk(d, {8'h00, synth_pkg::CFG_RESET});
    meas(1'b0, 2, 1);
    rd(12'h004, d, r);
    chk(32'(r), 32'(synth_pkg::RESP_SLVERR));
    wr(12'h004, 32'h00F00004, r);
    chk(32'(r), 32'(synth_pkg::RESP_SLVERR));
    $display("test reset and map done");
    for (int i = 0; i < 4; i++) begin
      n = 2 + {$random(seed)} % 30;
      wr(synth_pkg::ADDR_CFG_B, 32'(n), r);
      meas(1'b1, n, (n + 1) / 2);
    end
    $display("test regular done");
    wr(synth_pkg::ADDR_CFG_A, 32'h00F00004, r);
    meas(1'b0, 4 * TP, 2 * TP);
    wr(synth_pkg::ADDR_CFG_B, 32'h00F10003, r);
    meas(1'b1, 3 * TP, 2 * TP);
    $display("test low clock done");
    for (int i = 0; i < 6; i++) begin
      wr(i < 3 ? synth_pkg::ADDR_CFG_A : synth_pkg::ADDR_CFG_B, SIB[i], r);
      wr(i < 3 ? synth_pkg::ADDR_CFG_B : synth_pkg::ADDR_CFG_A, TGT[i], r);
      meas(i < 3, PER[i], HI[i]);
    end
    $display("test frame done");
    wr(synth_pkg::ADDR_CFG_B, 32'hFF0C0003, r);
    rd(synth_pkg::ADDR_CFG_B, d, r);
    chk(d, 32'h000C0003);
    rd(synth_pkg::ADDR_STATUS, d, r);
    chk(32'(d[5:2]), 32'h2);
    $display("test ratio bits done");
    tally_and_finish;
  end
endmodule
